// ===== hw/dsrec_ctrl.sv
// Disturbance recorder control: triggering, storage bookkeeping and readouts
`timescale 1ns/1ps
module dsrec_ctrl #(
    parameter int DIG_PERIOD = dsrec_pkg::DIG_PERIOD_CYC,
    parameter int HIST_DEPTH = 6000
) (
    // Clock and reset
    input  wire logic                          REF_CLK_IN,
    input  wire logic                          RST_IN,
    // Settings and commands
    input  wire dsrec_pkg::dsrec_cfg_type      CFG_IN,
    input  wire dsrec_pkg::dsrec_cmd_type      CMD_IN,
    input  wire logic                          MANUAL_TRIG_IN,
    input  wire logic                          REC_DONE_IN,
    // Signals from the relay
    input  wire logic [dsrec_pkg::DIG_CH-1:0]  DIG_SIG_IN,
    input  wire logic [31:0]                   ANA_SAMPLE_WORDS_IN,
    // Status and readouts
    output dsrec_pkg::dsrec_status_type        STATUS_OUT,
    output logic [dsrec_pkg::CNT_W-1:0]        REC_COUNT_OUT,
    output logic [dsrec_pkg::CNT_W-1:0]        MAX_REC_OUT,
    output logic [dsrec_pkg::MS_W-1:0]         MAX_LEN_MS_OUT,
    output logic [dsrec_pkg::MS_W-1:0]         MAX_PRE_MS_OUT,
    output logic [dsrec_pkg::CNT_W-1:0]        LOCAL_COUNT_OUT,
    output logic [2:0]                         XFER_COUNT_OUT,
    output logic                               REC_START_OUT,
    output logic                               DIG_TICK_OUT,
    output logic [dsrec_pkg::DIG_CH-1:0]       DIG_SAMPLE_OUT,
    output logic                               MANUAL_TRIG_OUT
);
    localparam int CW = dsrec_pkg::CNT_W;
    localparam int DW = $clog2(DIG_PERIOD);

    typedef struct packed {
        dsrec_pkg::dsrec_status_type status;
        logic [CW-1:0]       count;
        logic [CW-1:0]       xfer_pending;
        logic [2:0]          xfer_held;
        logic [CW-1:0]       max_rec;
        logic [dsrec_pkg::MS_W-1:0] max_len;
        logic [dsrec_pkg::MS_W-1:0] max_pre;
        logic [DW-1:0]       div;
        logic                tick;
        logic                start;
        logic                manual;
        logic                manual_seen;
        logic                busy;
        logic [CW-1:0]       local_cnt;
    } dsrec_state_type;

    dsrec_state_type state;
    dsrec_state_type next_state;

    // Three-stage synchroniser on the trigger and channel sources
    logic [dsrec_pkg::DIG_CH-1:0] sync1;
    logic [dsrec_pkg::DIG_CH-1:0] sync2;
    logic [dsrec_pkg::DIG_CH-1:0] sync3;
    logic [dsrec_pkg::DIG_CH-1:0] sig_stable;
    logic [dsrec_pkg::DIG_CH-1:0] sig_prev;
    logic [dsrec_pkg::DIG_CH-1:0] hist_oldest;
    logic [$clog2(HIST_DEPTH+1)-1:0] hist_fill;

    // Samples per cycle for a rate code
    function automatic logic [6:0] spc(input dsrec_pkg::dsrec_rate_type r);
        case (r)
            dsrec_pkg::RATE_64: spc = 7'h40;
            dsrec_pkg::RATE_32: spc = 7'h20;
            dsrec_pkg::RATE_16: spc = 7'h10;
            default:            spc = 7'h08;
        endcase
    endfunction

    function automatic logic [6:0] popcnt(input logic [dsrec_pkg::DIG_CH-1:0] v);
        popcnt = '0;
        for (int i = 0; i < dsrec_pkg::DIG_CH; i++)
        begin
            popcnt = popcnt + 7'(v[i]);
        end
    endfunction

    logic [6:0]  n_ana;
    logic [6:0]  n_dig;
    logic [31:0] words_per_s;
    logic [31:0] total_ms;
    logic [31:0] len_ms;
    logic [31:0] pre_ms;
    logic [31:0] per_rec;
    logic        trig_hit;
    logic        take_trig;
    logic        cfg_bad;

    // Rate math uses one division per path; fine at settings-change speed
    always_comb
    begin
        n_ana = popcnt({76'h0, CFG_IN.ana_used}); // RULE19
        n_dig = popcnt(CFG_IN.dig_sel); // RULE20
        words_per_s = 32'(dsrec_pkg::NOM_HZ) * 32'(n_ana + 7'h01) * 32'(spc(CFG_IN.rate)) // RULE16
                    + dsrec_pkg::DIG_RATE_HZ * 32'(n_dig) + ANA_SAMPLE_WORDS_IN;
        total_ms = 32'((64'(dsrec_pkg::SAMPLE_RESERVE) * 64'h3E8) / 64'(words_per_s));
        if (CFG_IN.trig_sel == '0)
        begin
            total_ms = '0; // RULE22
        end
        if (total_ms > 32'(dsrec_pkg::MAX_LEN_MS))
        begin
            total_ms = 32'(dsrec_pkg::MAX_LEN_MS);
        end
        len_ms = 32'(CFG_IN.len_steps) * 32'(dsrec_pkg::LEN_STEP_MS); // RULE14
        pre_ms = 32'(CFG_IN.pre_steps) * 32'(dsrec_pkg::PRE_STEP_MS); // RULE18
        per_rec = (len_ms == '0) ? 32'h1 : len_ms;
        cfg_bad = (len_ms == '0) || (pre_ms >= len_ms) || (n_ana == '0 && n_dig == '0);
        trig_hit = |(CFG_IN.trig_sel & sig_stable & ~sig_prev); // RULE1
    end

    always_comb
    begin
        next_state = state;
        next_state.start = 1'b0;
        // Fixed 5 ms digital sampling strobe
        if (state.div == DW'(DIG_PERIOD - 1))
        begin
            next_state.div = '0;
            next_state.tick = 1'b1; // RULE17
        end
        else
        begin
            next_state.div = state.div + 1'b1;
            next_state.tick = 1'b0;
        end
        next_state.max_len = dsrec_pkg::MS_W'(total_ms); // RULE11
        next_state.max_pre = (total_ms > pre_ms) ? dsrec_pkg::MS_W'(total_ms - pre_ms)
                           : '0; // RULE12
        if (total_ms / per_rec >= 32'(dsrec_pkg::MAX_REC))
        begin
            next_state.max_rec = CW'(dsrec_pkg::MAX_REC); // RULE10
        end
        else
        begin
            next_state.max_rec = CW'(total_ms / per_rec);
        end
        // Manual command clears itself once taken
        if (MANUAL_TRIG_IN && !state.manual_seen)
        begin
            next_state.manual = 1'b1;
        end
        next_state.manual_seen = MANUAL_TRIG_IN;
        take_trig = (state.manual || trig_hit) && !state.busy && !CFG_IN.rec_disable // RULE3
                  && !cfg_bad && state.max_len != '0
                  && !(CFG_IN.keep_old && state.count >= state.max_rec); // RULE15
        if (take_trig)
        begin
            next_state.manual = 1'b0; // RULE6
            next_state.busy = 1'b1;
            next_state.start = 1'b1;
        end
        if (state.busy && REC_DONE_IN)
        begin
            next_state.busy = 1'b0;
            if (state.count < state.max_rec)
            begin
                next_state.count = state.count + 1'b1; // RULE2
            end
            if (CFG_IN.auto_xfer)
            begin
                next_state.xfer_pending = next_state.xfer_pending + 1'b1; // RULE21
            end
        end
        if (CMD_IN.xfer_removed && state.xfer_held != '0)
        begin
            next_state.xfer_held = state.xfer_held - 1'b1;
        end
        if (state.xfer_pending != '0 && next_state.xfer_held < 3'(dsrec_pkg::XFER_MAX))
        begin
            next_state.xfer_pending = next_state.xfer_pending - 1'b1; // RULE21
            next_state.xfer_held = next_state.xfer_held + 1'b1;
        end
        if (CMD_IN.clear_all)
        begin
            next_state.count = '0; // RULE7
        end
        else if ((CMD_IN.clear_newest || CMD_IN.clear_oldest) && next_state.count != '0)
        begin
            next_state.count = next_state.count - 1'b1; // RULE8 RULE9
        end
        else if (CMD_IN.clear_sel && CMD_IN.clear_index != '0
                 && CMD_IN.clear_index <= 32'(next_state.count))
        begin
            next_state.count = next_state.count - 1'b1; // RULE5
        end
        if (next_state.count > next_state.max_rec)
        begin
            next_state.count = next_state.max_rec; // RULE2
        end
        // Registered so the readout comes straight from a flop
        next_state.local_cnt = next_state.count - CW'(next_state.xfer_held)
                             - next_state.xfer_pending; // RULE21
        if (cfg_bad)
        begin
            next_state.status = dsrec_pkg::ST_BAD_CFG; // RULE4
        end
        else if (next_state.busy && state.status == dsrec_pkg::ST_READY)
        begin
            next_state.status = dsrec_pkg::ST_TRIGGERED;
        end
        else if (next_state.busy)
        begin
            next_state.status = dsrec_pkg::ST_REC_STORE;
        end
        else if (state.busy)
        begin
            next_state.status = dsrec_pkg::ST_STORING;
        end
        else if (CFG_IN.keep_old && next_state.count >= next_state.max_rec)
        begin
            next_state.status = dsrec_pkg::ST_FULL;
        end
        else if (state.max_len != '0)
        begin
            next_state.status = dsrec_pkg::ST_READY; // RULE22
        end
        else
        begin
            next_state.status = dsrec_pkg::ST_BAD_CFG;
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        sync1 <= DIG_SIG_IN;
        sync2 <= sync1;
        sync3 <= sync2;
        if (RST_IN)
        begin
            state <= '0;
            // Not ready while the capacity readout is still zero
            state.status <= dsrec_pkg::ST_BAD_CFG; // RULE22
            sig_stable <= '0;
            sig_prev <= '0;
        end
        else
        begin
            state <= next_state;
            sig_prev <= sig_stable;
            for (int i = 0; i < dsrec_pkg::DIG_CH; i++)
            begin
                if (sync2[i] == sync3[i])
                begin
                    sig_stable[i] <= sync3[i];
                end
            end
        end
    end

    dsrec_history #(
        .WIDTH (dsrec_pkg::DIG_CH),
        .DEPTH (HIST_DEPTH)
    ) u_history (
        .clk_in     (REF_CLK_IN),
        .rst_in     (RST_IN),
        .tick_in    (state.tick),
        .data_in    (sig_stable & CFG_IN.dig_sel),
        .oldest_out (hist_oldest),
        .fill_out   (hist_fill)
    );

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            DIG_SAMPLE_OUT <= '0;
        end
        else if (state.tick && hist_fill == $clog2(HIST_DEPTH+1)'(HIST_DEPTH))
        begin
            // Waits for a full ring so no unwritten slot escapes
            DIG_SAMPLE_OUT <= hist_oldest; // RULE23
        end
    end

    // Outputs stay flop-driven through the state record
    always_comb
    begin
        STATUS_OUT = state.status;
        REC_COUNT_OUT = state.count; // RULE13
        LOCAL_COUNT_OUT = state.local_cnt;
        XFER_COUNT_OUT = state.xfer_held;
        MAX_REC_OUT = state.max_rec;
        MAX_LEN_MS_OUT = state.max_len;
        MAX_PRE_MS_OUT = state.max_pre;
        REC_START_OUT = state.start;
        DIG_TICK_OUT = state.tick;
        MANUAL_TRIG_OUT = state.manual;
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_COUNT_CAP: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE2
        REC_COUNT_OUT <= 7'h64) else $error("Stored count above 100");
    AST_MAXREC_CAP: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE10
        MAX_REC_OUT <= 7'h64) else $error("Max recordings above 100");
    AST_XFER_CAP: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE21
        XFER_COUNT_OUT <= 3'h6) else $error("Transfer store above six");
    AST_CLEAR_ALL: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE7
        CMD_IN.clear_all |=> REC_COUNT_OUT == '0) else $error("Clear all kept records");
    AST_DISABLED: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE3
        CFG_IN.rec_disable |=> !REC_START_OUT) else $error("Start while disabled");
    AST_READY_LEN: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE22
        STATUS_OUT == dsrec_pkg::ST_READY |-> $past(MAX_LEN_MS_OUT) != '0)
        else $error("Ready with zero max length");
    AST_MANUAL_RET: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE6
        REC_START_OUT && $past(MANUAL_TRIG_OUT) |-> !MANUAL_TRIG_OUT)
        else $error("Manual command did not return");
    AST_TICK_GAP: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE17
        DIG_TICK_OUT |=> !DIG_TICK_OUT [*2]) else $error("Digital strobe too fast");
    AST_NO_TRIG_READY: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN) // RULE22
        CFG_IN.trig_sel == '0 |=> MAX_LEN_MS_OUT == '0)
        else $error("Length without trigger");

    COV_START: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN) REC_START_OUT);
    COV_FULL: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        STATUS_OUT == dsrec_pkg::ST_FULL);
    COV_STORE: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        STATUS_OUT == dsrec_pkg::ST_STORING);
endmodule

// ===== hw/dsrec_history.sv
// Rolling pre-trigger history of the digital channels
`timescale 1ns/1ps
module dsrec_history #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 6000
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Sample stream
    input  wire logic             tick_in,
    input  wire logic [WIDTH-1:0] data_in,
    // Oldest retained sample and fill depth
    output logic [WIDTH-1:0]      oldest_out,
    output logic [$clog2(DEPTH+1)-1:0] fill_out
);
    typedef struct packed {
        logic [$clog2(DEPTH)-1:0]   wr_ptr;
        logic [$clog2(DEPTH+1)-1:0] fill;
    } dsrec_hist_type;

    dsrec_hist_type   state;
    dsrec_hist_type   next_state;
    logic [WIDTH-1:0] mem [DEPTH];

    always_comb
    begin
        next_state = state;
        if (tick_in)
        begin
            // Ring overwrites forever; history is full only after DEPTH ticks
            next_state.wr_ptr = (state.wr_ptr == $clog2(DEPTH)'(DEPTH - 1)) ? '0
                              : state.wr_ptr + 1'b1; // RULE23
            if (state.fill != $clog2(DEPTH+1)'(DEPTH))
            begin
                next_state.fill = state.fill + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
        if (tick_in)
        begin
            mem[state.wr_ptr] <= data_in;
        end
        oldest_out <= mem[next_state.wr_ptr];
    end

    assign fill_out = state.fill;
endmodule

// ===== include/dsrec_pkg.sv
// Constants and carrier types of the disturbance recorder control block
// Summary of operation
// RULE1: Recording starts on manual command or any enabled trigger source firing.
// RULE2: Never more than 100 stored recordings, however small.
// RULE3: Enable code 0 turns recorder on, 1 off; reset value is enabled.
// RULE4: Status code: 0 ready,1 triggered,2 recording+storing,3 storing,4 full,5 bad config.
// RULE5: Selective clear index N deletes the Nth stored recording, counted from one.
// RULE6: Manual trigger 1 starts one recording, then command returns to 0 itself.
// RULE7: Clear-all command deletes every stored recording.
// RULE8: Clear-newest command deletes only the most recent recording.
// RULE9: Clear-oldest command deletes only the earliest recording still held.
// RULE10: Readout of maximum recordings fitting memory, capped at 100.
// RULE11: Readout of longest single recording, in milliseconds.
// RULE12: Readout of largest permitted pre-trigger time, in milliseconds.
// RULE13: Readout of how many recordings are stored now.
// RULE14: Recording length set in 10 ms steps, default 1 s.
// RULE15: Full memory: mode 0 overwrites oldest, mode 1 refuses; mode 0 default.
// RULE16: Analog rate codes 0..3 select 64,32,16,8 samples per cycle; default 0.
// RULE17: Digital channels are sampled every fixed 5 ms.
// RULE18: Pre-trigger history set in 100 ms steps, default 0.2 s.
// RULE19: Each analog slot takes one channel from the list or stays unused.
// RULE20: Recorded digital channels are freely selectable from binary signals.
// RULE21: Auto transfer pushes recordings, at most 6 outstanding, hidden from local reads.
// RULE22: Ready only when computed max length is non-zero; needs a trigger selected.
// RULE23: A history buffer at least as long as the pre-trigger time runs always; the code holds 6000 samples (30000 ms), pre-trigger settable to 51100 ms.
package dsrec_pkg;
    localparam int MAX_REC = 100;
    localparam int XFER_MAX = 6;
    localparam int ANA_SLOTS = 20;
    localparam int ANA_SEL_W = 5;
    localparam int DIG_CH = 96;
    localparam int CNT_W = 7;
    localparam int MS_W = 21;
    localparam int CLK_MHZ = 100;
    localparam int DIG_PERIOD_MS = 5;
    localparam int DIG_PERIOD_CYC = DIG_PERIOD_MS * CLK_MHZ * 1000;
    localparam int LEN_STEP_MS = 10;
    localparam int PRE_STEP_MS = 100;
    localparam int NOM_HZ = 50;
    localparam int MAX_LEN_MS = 1800000;
    localparam logic [7:0] LEN_RESET = 8'h64;
    localparam logic [8:0] PRE_RESET = 9'h002;
    localparam logic SAMPLE_BITS_SHIFT = 1'b0;
    localparam logic [31:0] SAMPLE_RESERVE = 32'h00F54F67;
    localparam logic [31:0] DIG_RATE_HZ = 32'h000000C8;

    typedef enum logic [2:0] {
        ST_READY, ST_TRIGGERED, ST_REC_STORE, ST_STORING, ST_FULL, ST_BAD_CFG
    } dsrec_status_type;

    typedef enum logic [1:0] {
        RATE_64, RATE_32, RATE_16, RATE_8
    } dsrec_rate_type;

    typedef struct packed {
        logic           rec_disable;
        logic           keep_old;
        dsrec_rate_type rate;
        logic [17:0]    len_steps;
        logic [8:0]     pre_steps;
        logic           auto_xfer;
        logic [ANA_SLOTS-1:0] ana_used;
        logic [DIG_CH-1:0]    dig_sel;
        logic [DIG_CH-1:0]    trig_sel;
    } dsrec_cfg_type;

    typedef struct packed {
        logic        clear_all;
        logic        clear_newest;
        logic        clear_oldest;
        logic        clear_sel;
        logic [31:0] clear_index;
        logic        xfer_removed;
    } dsrec_cmd_type;
endpackage

// ===== tb/dsrec_ctrl_bench.sv
// Self-checking bench of the disturbance recorder control block
`timescale 1ns/1ps
module dsrec_ctrl_bench;
    localparam int DIG_PERIOD = 10;
    localparam int HIST_DEPTH = 16;
    localparam int RESERVE    = 16076647;

    logic                                ref_clk;
    logic                                rst;
    dsrec_pkg::dsrec_cfg_type            cfg;
    dsrec_pkg::dsrec_cmd_type            cmd;
    logic                                manual_trig;
    logic                                rec_done;
    logic [dsrec_pkg::DIG_CH-1:0]        dig_sig;
    logic [31:0]                         ana_words;
    dsrec_pkg::dsrec_status_type         status;
    logic [dsrec_pkg::CNT_W-1:0]         rec_count;
    logic [dsrec_pkg::CNT_W-1:0]         max_rec;
    logic [dsrec_pkg::MS_W-1:0]          max_len;
    logic [dsrec_pkg::MS_W-1:0]          max_pre;
    logic [dsrec_pkg::CNT_W-1:0]         local_count;
    logic [2:0]                          xfer_count;
    logic                                rec_start;
    logic                                dig_tick;
    logic [dsrec_pkg::DIG_CH-1:0]        dig_sample;
    logic                                manual_out;
    int                                  errors;
    int                                  check_count;
    int                                  i;
    int                                  n;
    logic                                started;

    dsrec_ctrl #(
        .DIG_PERIOD (DIG_PERIOD),
        .HIST_DEPTH (HIST_DEPTH)
    ) uut (
        .REF_CLK_IN          (ref_clk),
        .RST_IN              (rst),
        .CFG_IN              (cfg),
        .CMD_IN              (cmd),
        .MANUAL_TRIG_IN      (manual_trig),
        .REC_DONE_IN         (rec_done),
        .DIG_SIG_IN          (dig_sig),
        .ANA_SAMPLE_WORDS_IN (ana_words),
        .STATUS_OUT          (status),
        .REC_COUNT_OUT       (rec_count),
        .MAX_REC_OUT         (max_rec),
        .MAX_LEN_MS_OUT      (max_len),
        .MAX_PRE_MS_OUT      (max_pre),
        .LOCAL_COUNT_OUT     (local_count),
        .XFER_COUNT_OUT      (xfer_count),
        .REC_START_OUT       (rec_start),
        .DIG_TICK_OUT        (dig_tick),
        .DIG_SAMPLE_OUT      (dig_sample),
        .MANUAL_TRIG_OUT     (manual_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Expectations and comparisons

    // Floor to whole ms; 64-bit to keep the reserve times 1000 exact
    function automatic int exp_len_ms(input int n_ana, input int n_dig, input int sr);
        longint den;
        longint ms;
        den = dsrec_pkg::NOM_HZ * (n_ana + 1) * sr + 200 * n_dig;
        ms = (longint'(RESERVE) * 1000) / den;
        return (ms > dsrec_pkg::MAX_LEN_MS) ? dsrec_pkg::MAX_LEN_MS : int'(ms);
    endfunction

    task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d, checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Drivers

    task automatic step(input int cycles);
        repeat (cycles) @(posedge ref_clk);
        #1;
    endtask

    // Kind 0 all, 1 newest, 2 oldest, 3 selective
    task automatic clear_op(input int kind, input int idx);
        cmd.clear_all = (kind == 0);
        cmd.clear_newest = (kind == 1);
        cmd.clear_oldest = (kind == 2);
        cmd.clear_sel = (kind == 3);
        cmd.clear_index = idx;
        step(1);
        cmd = '0;
        step(2);
    endtask

    // Follows the documented manual walk cycle by cycle
    task automatic record_walk(input int cnt);
        manual_trig = 1'h1;
        step(1);
        chk_bit(manual_out, 1'h1, "manual pending");
        step(1);
        chk_bit(rec_start, 1'h1, "start pulse");
        chk_bit(manual_out, 1'h0, "manual back to idle");
        chk_num(status, dsrec_pkg::ST_TRIGGERED, "status");
        manual_trig = 1'h0;
        step(1);
        chk_bit(rec_start, 1'h0, "start width");
        chk_num(status, dsrec_pkg::ST_REC_STORE, "status");
        rec_done = 1'h1;
        step(1);
        rec_done = 1'h0;
        chk_num(status, dsrec_pkg::ST_STORING, "status");
        chk_num(rec_count, cnt, "count");
        step(1);
        chk_num(status, dsrec_pkg::ST_READY, "status");
    endtask

    // Source below zero is the manual command, else a signal bit
    task automatic quick_record(input int src, output logic got);
        int k;
        got = 1'h0;
        if (src < 0)
            manual_trig = 1'h1;
        else
            dig_sig[src] = 1'h1;
        for (k = 0; k < 12 && !got; k++)
        begin
            step(1);
            if (rec_start === 1'h1)
                got = 1'h1;
        end
        manual_trig = 1'h0;
        if (src >= 0)
            dig_sig[src] = 1'h0;
        if (got)
        begin
            step(1);
            rec_done = 1'h1;
            step(1);
            rec_done = 1'h0;
        end
        // Lets the falling level clear the synchronisers first
        step(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and tests

    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // About ten times the expected run length
    initial
    begin
        #200000;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        errors = 0;
        check_count = 0;
        rst = 1'h1;
        cmd = '0;
        cfg = '0;
        cfg.len_steps = 18'h00064;
        cfg.pre_steps = 9'h002;
        cfg.ana_used = 20'h001FF;
        cfg.dig_sel = 96'h3;
        cfg.trig_sel = 96'h1;
        manual_trig = 1'h0;
        rec_done = 1'h0;
        dig_sig = '0;
        ana_words = 32'h0;
        step(4);
        rst = 1'h0;
        step(3);
        chk_num(status, dsrec_pkg::ST_READY, "ready after reset");
        chk_num(rec_count, 32'h0, "count after reset");
        chk_num(max_rec, 32'h64, "max recordings");
        chk_num(max_len, exp_len_ms(9, 2, 64), "max length");
        chk_bit(max_pre != 0 && max_pre <= max_len, 1'h1, "max pre");
        for (i = 0; i < 4; i++)
        begin
            cfg.rate = dsrec_pkg::dsrec_rate_type'(i);
            step(3);
            chk_num(max_len, exp_len_ms(9, 2, 64 >> i), "length per rate");
        end
        cfg.rate = dsrec_pkg::RATE_64;
        cfg.trig_sel = '0;
        step(3);
        chk_num(max_len, 32'h0, "length without trigger");
        chk_bit(status === dsrec_pkg::ST_READY, 1'h0, "not ready");
        cfg.trig_sel = 96'h1;
        step(3);
        for (i = 1; i <= 3; i++)
            record_walk(i);
        clear_op(1, 0);
        chk_num(rec_count, 32'h2, "clear newest");
        clear_op(2, 0);
        chk_num(rec_count, 32'h1, "clear oldest");
        record_walk(2);
        record_walk(3);
        clear_op(3, 0);
        chk_num(rec_count, 32'h3, "clear index zero");
        clear_op(3, 4);
        chk_num(rec_count, 32'h3, "clear index beyond");
        clear_op(3, 2);
        chk_num(rec_count, 32'h2, "clear index two");
        clear_op(0, 0);
        chk_num(rec_count, 32'h0, "clear all");
        cfg.rec_disable = 1'h1;
        step(2);
        quick_record(0, started);
        chk_bit(started, 1'h0, "disabled start");
        cfg.rec_disable = 1'h0;
        step(2);
        quick_record(0, started);
        chk_bit(started, 1'h1, "signal start");
        quick_record(1, started);
        chk_bit(started, 1'h0, "unselected signal");
        clear_op(0, 0);
        cfg.keep_old = 1'h1;
        cfg.len_steps = 18'h04650;
        step(3);
        chk_num(max_rec, exp_len_ms(9, 2, 64) / 180000, "max rec long");
        quick_record(0, started);
        quick_record(0, started);
        chk_num(status, dsrec_pkg::ST_FULL, "full");
        quick_record(0, started);
        chk_bit(started, 1'h0, "keep old refuses");
        cfg.keep_old = 1'h0;
        step(2);
        quick_record(0, started);
        chk_bit(started, 1'h1, "fifo accepts");
        chk_num(rec_count, 32'h2, "fifo count");
        cfg.len_steps = 18'h00064;
        clear_op(0, 0);
        for (i = 0; i < 101; i++)
            quick_record(-1, started);
        chk_num(rec_count, 32'h64, "count cap");
        clear_op(0, 0);
        cfg.auto_xfer = 1'h1;
        for (i = 0; i < 7; i++)
            quick_record(-1, started);
        chk_num(xfer_count, 32'h6, "transfer store");
        chk_num(local_count, 32'h0, "pending not local");
        cmd.xfer_removed = 1'h1;
        step(1);
        cmd = '0;
        step(2);
        chk_num(xfer_count, 32'h6, "store refilled");
        chk_num(local_count, 32'h1, "local after push");
        n = 0;
        while (dig_tick !== 1'h1 && n < 50)
        begin
            step(1);
            n++;
        end
        n = 0;
        do
        begin
            step(1);
            n++;
        end while (dig_tick !== 1'h1 && n < 50);
        chk_num(n, DIG_PERIOD, "tick spacing");
        cfg.dig_sel[95:88] = 8'hFF;
        dig_sig[95:88] = 8'hA5;
        step(DIG_PERIOD * 20);
        chk_num(dig_sample[95:88], 32'hA5, "history settled");
        dig_sig[95:88] = 8'h3C;
        step(DIG_PERIOD * 8);
        chk_num(dig_sample[95:88], 32'hA5, "history depth");
        step(DIG_PERIOD * 14);
        chk_num(dig_sample[95:88], 32'h3C, "history update");
        close_out();
    end
endmodule
